// File: design/prsl_top.sv
// PHY reset sequencer with strap latch and basic control reset bit
`timescale 1ns/1ps
`default_nettype none
module prsl_top
  import prsl_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Reset pin and power-on
  input wire logic reset_pin,
  input wire logic por_done,
  // Strap inputs sampled from shared pins
  input wire logic fibre_enable_strap_in,
  input wire logic symbol_strap_in,
  input wire logic [4:0] phy_address_strap_in,
  input wire logic coax_select_pin,
  input wire logic bitwise_low_rate_strap_in,
  // Control register write port (address 00h)
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  output logic [15:0] ctrl_rdata,
  // Activity for carrier sense
  input wire logic rx_active,
  input wire logic tx_active,
  output logic carrier_sense,
  // Status and latched straps
  output logic internal_reset,
  output logic low_rate_indicator,
  output logic fibre_enable_strap,
  output logic symbol_strap,
  output logic [4:0] phy_address_strap,
  output logic repeater_strap,
  output logic bitwise_low_rate_strap
);
  prsl_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] pin_cnt_q, pin_cnt_d;
  logic soft_q, soft_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [8:0] straps_q, straps_d;
  logic pin_reset;
  logic [8:0] strap_pins;
  // Delay bounds in assertions need a constant of this file
  localparam int LATCH_SPAN = LATCH_CYC;

  // Short glitches on the pin are ignored; only a full 1 us pulse counts
  assign pin_reset = (pin_cnt_q >= CNT_W'(PIN_MIN_CYC));

  // Strap pin levels in the order they are stored
  assign strap_pins = {fibre_enable_strap_in, symbol_strap_in,
    phy_address_strap_in, coax_select_pin,
    bitwise_low_rate_strap_in};

  always_comb begin
    pin_cnt_d = reset_pin ? pin_cnt_q : '0;
    if (reset_pin && !pin_reset) begin
      pin_cnt_d = pin_cnt_q + 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    soft_d = soft_q;
    ctrl_d = ctrl_q;
    straps_d = straps_q;
    case (state_q)
      PRSL_POR: begin
        cnt_d = cnt_q + 1'b1;
        if (por_done && cnt_q >= CNT_W'(POR_CYCLES)) begin
          state_d = PRSL_HOLD;
          cnt_d = '0;
        end
      end
      PRSL_HOLD: begin
        // Straps track the pins while reset holds
        straps_d = strap_pins;
        if (!reset_pin && !soft_q) begin
          state_d = PRSL_LATCH;
          cnt_d = '0;
        end
      end
      PRSL_LATCH: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(LATCH_CYC - 1)) begin
          state_d = PRSL_RUN;
          ctrl_d = CTRL_DEFAULT;
          ctrl_d[CTRL_ISOLATE_BIT] = (straps_q[6:2] == ADDR_ZERO);
        end
      end
      PRSL_RUN: begin
        if (soft_q) begin
          // Soft reset skips the hold state, so straps are taken here
          straps_d = strap_pins;
          cnt_d = cnt_q + 1'b1;
          // Part of the 5 us is spent relatching, so hold ends early
          if (cnt_q == CNT_W'(SOFT_CYC - LATCH_CYC - 1)) begin
            soft_d = 1'b0;
            state_d = PRSL_LATCH;
            cnt_d = '0;
          end
        end
        if (ctrl_wr) begin
          ctrl_d = ctrl_wdata;
          ctrl_d[CTRL_RESET_BIT] = 1'b0;
          if (ctrl_wdata[CTRL_RESET_BIT]) begin
            soft_d = 1'b1;
            state_d = PRSL_RUN;
            cnt_d = '0;
          end
        end
      end
      default: state_d = PRSL_POR;
    endcase
    if (pin_reset && state_q != PRSL_POR) begin
      state_d = PRSL_HOLD;
      soft_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= PRSL_POR;
      cnt_q <= '0;
      pin_cnt_q <= '0;
      soft_q <= 1'b0;
      ctrl_q <= CTRL_DEFAULT;
      straps_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pin_cnt_q <= pin_cnt_d;
      soft_q <= soft_d;
      ctrl_q <= ctrl_d;
      straps_q <= straps_d;
    end
  end

  assign internal_reset = (state_q != PRSL_RUN) || soft_q;
  always_comb begin
    ctrl_rdata = ctrl_q;
    ctrl_rdata[CTRL_RESET_BIT] = soft_q;
  end
  assign low_rate_indicator = internal_reset;
  assign {fibre_enable_strap, symbol_strap, phy_address_strap,
    repeater_strap, bitwise_low_rate_strap} = straps_q;
  assign carrier_sense = internal_reset ? 1'b0 :
    (rx_active || (!repeater_strap && tx_active));

  // Age of a running soft reset; a pin reset takes over and clears it
  logic [CNT_W-1:0] sw_age_q, sw_age_d;
  always_comb begin
    sw_age_d = '0;
    if (internal_reset && !pin_reset && (soft_q || sw_age_q != '0)) begin
      sw_age_d = sw_age_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_age_q <= '0;
    end else begin
      sw_age_q <= sw_age_d;
    end
  end

  // Soft reset steps: busy with the bit set, then relatch, then run
  sequence soft_write_s;
    state_q == PRSL_RUN && ctrl_wr && ctrl_wdata[CTRL_RESET_BIT];
  endsequence
  sequence soft_busy_s;
    soft_q && ctrl_rdata[CTRL_RESET_BIT] && state_q == PRSL_RUN;
  endsequence
  sequence soft_last_s;
    soft_q && cnt_q == CNT_W'(SOFT_CYC - LATCH_CYC - 1);
  endsequence
  sequence relatch_s;
    state_q == PRSL_LATCH && !soft_q && low_rate_indicator;
  endsequence

  sw_done_a: assert property (@(posedge clk) disable iff (reset)
    $fell(soft_q) && !pin_reset |=> state_q == PRSL_LATCH)
    else $error("soft reset did not move to latch");
  speed_hold_a: assert property (@(posedge clk) disable iff (reset)
    state_q != PRSL_RUN || soft_q |-> low_rate_indicator)
    else $error("low rate indicator dropped in reset");
  isolate_def_a: assert property (@(posedge clk) disable iff (reset)
    state_q == PRSL_LATCH && state_d == PRSL_RUN |=>
    ctrl_q[CTRL_ISOLATE_BIT] == (phy_address_strap == ADDR_ZERO))
    else $error("isolate default wrong");
  pin_reset_a: assert property (@(posedge clk) disable iff (reset)
    pin_reset && state_q != PRSL_POR |=> state_q == PRSL_HOLD)
    else $error("pin reset not taken");
  sw_start_a: assert property (@(posedge clk) disable iff (reset)
    soft_write_s ##0 !pin_reset |=> soft_q && ctrl_rdata[CTRL_RESET_BIT])
    else $error("soft reset not started");
  latch_time_a: assert property (@(posedge clk) disable iff (reset)
    $rose(state_q == PRSL_LATCH) && !pin_reset && !soft_q
    |-> ##[1:LATCH_SPAN] state_q != PRSL_LATCH)
    else $error("straps not latched in time");
  crs_rep_a: assert property (@(posedge clk) disable iff (reset)
    !internal_reset && repeater_strap && !rx_active |-> !carrier_sense)
    else $error("carrier in repeater mode without receive");
  crs_node_a: assert property (@(posedge clk) disable iff (reset)
    !internal_reset && !repeater_strap && tx_active |-> carrier_sense)
    else $error("carrier missing for transmit in node mode");
  hold_rel_a: assert property (@(posedge clk) disable iff (reset)
    state_q == PRSL_HOLD && reset_pin |=> state_q == PRSL_HOLD)
    else $error("reset released while pin held");
  strap_hold_a: assert property (@(posedge clk) disable iff (reset)
    state_q == PRSL_RUN && !soft_q |=> $stable(straps_q))
    else $error("straps moved while running");
  strap_take_a: assert property (@(posedge clk) disable iff (reset)
    state_q == PRSL_HOLD || soft_q |=> straps_q == $past(strap_pins))
    else $error("straps not taken from pins");
  soft_steps_a: assert property (@(posedge clk)
    disable iff (reset || pin_reset)
    soft_write_s |=> soft_busy_s [*8])
    else $error("reset bit not held while soft reset runs");
  soft_relatch_a: assert property (@(posedge clk)
    disable iff (reset || pin_reset)
    soft_last_s ##0 !ctrl_wr |=> relatch_s [*8])
    else $error("soft reset did not relatch");
  soft_len_a: assert property (@(posedge clk) disable iff (reset)
    internal_reset |-> sw_age_q < CNT_W'(SOFT_CYC))
    else $error("soft reset ran past its time");
  soft_done_a: assert property (@(posedge clk)
    disable iff (reset || pin_reset)
    sw_age_q == CNT_W'(SOFT_CYC - 1) |=> !internal_reset)
    else $error("soft reset did not finish in time");
endmodule
`default_nettype wire

// File: shared/prsl_pkg.sv
// Constants for the PHY reset and strap latch block
package prsl_pkg;
  localparam int CLK_MHZ = 250;
  localparam int PIN_MIN_NS = 1000;
  localparam int PIN_MIN_CYC = (PIN_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int LATCH_MAX_NS = 2000;
  localparam int LATCH_CYC = (LATCH_MAX_NS * CLK_MHZ) / 1000 / 2;
  localparam int SOFT_NS = 5000;
  localparam int SOFT_CYC = (SOFT_NS * CLK_MHZ) / 1000;
  localparam int POR_NS = 500000;
  localparam int POR_CYC = (POR_NS / 1000) * CLK_MHZ;
  localparam int CNT_W = 18;
  localparam logic [4:0] ADDR_ZERO = 5'h00;
  localparam int CTRL_RESET_BIT = 15;
  localparam int CTRL_ISOLATE_BIT = 10;
  localparam logic [15:0] CTRL_DEFAULT = 16'h0000;
  typedef enum logic [1:0] {PRSL_POR, PRSL_HOLD, PRSL_LATCH, PRSL_RUN} prsl_state_e;
endpackage

// File: testbench/prsl_rst_model.sv
// Board reset generator model driving the reset pin and power-on flag
`timescale 1ns/1ps
`default_nettype none
module prsl_rst_model (
  // Clock and command
  input wire logic clk,
  input wire logic go,
  input wire logic [9:0] len,
  // Reset pin and power-on
  output logic reset_pin,
  output logic por_done
);
  // Clock runs throughout, so reset always takes effect
  initial begin
    reset_pin = 1'b1;
    por_done = 1'b0;
    repeat (40) @(posedge clk);
    por_done <= 1'b1;
    repeat (300) @(posedge clk);
    reset_pin <= 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        reset_pin <= 1'b1;
        repeat (len) @(posedge clk);
        reset_pin <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/prsl_top_tb_top.sv
// Self-checking bench for the reset sequencer and strap latch
`timescale 1ns/1ps
`default_nettype none
module prsl_top_tb_top
  import prsl_pkg::*;
();
  logic clk, reset, go, ctrl_wr, rx_active, tx_active;
  logic [9:0] len;
  logic [8:0] s;
  logic [15:0] ctrl_wdata;
  wire logic reset_pin, por_done, carrier_sense, internal_reset;
  wire logic low_rate_indicator, fib, sym, rep, low;
  wire logic [4:0] adr;
  wire logic [15:0] ctrl_rdata;
  int num_errors = 0;
  int checked = 0;
  int n;
  prsl_rst_model i_model (.clk(clk), .go(go), .len(len),
    .reset_pin(reset_pin), .por_done(por_done));
  prsl_top #(.POR_CYCLES(20)) i_dut (.clk(clk), .reset(reset),
    .reset_pin(reset_pin), .por_done(por_done),
    .fibre_enable_strap_in(s[8]), .symbol_strap_in(s[7]),
    .phy_address_strap_in(s[6:2]), .coax_select_pin(s[1]),
    .bitwise_low_rate_strap_in(s[0]), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .rx_active(rx_active), .tx_active(tx_active),
    .carrier_sense(carrier_sense), .internal_reset(internal_reset),
    .low_rate_indicator(low_rate_indicator), .fibre_enable_strap(fib),
    .symbol_strap(sym), .phy_address_strap(adr), .repeater_strap(rep),
    .bitwise_low_rate_strap(low));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] exp_ctrl(input logic [8:0] v);
    return (v[6:2] == 5'h00) ? 16'h0400 : 16'h0000;
  endfunction
  task automatic wait_run();
    for (n = 0; n < 2000 && internal_reset !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic check_latched();
    chk({7'h0, fib, sym, adr, rep, low}, {7'h0, s});
    chk(ctrl_rdata, exp_ctrl(s));
    for (int j = 0; j < 4; j++) begin
      @(posedge clk) {rx_active, tx_active} <= 2'(j);
      @(posedge clk) #1;
      chk({15'h0, carrier_sense}, 16'(s[1] ? j[1] : j[1] | j[0]));
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial begin
    reset = 1'b1; go = 1'b0; len = 10'h0; ctrl_wr = 1'b0;
    ctrl_wdata = 16'h0; rx_active = 1'b0; tx_active = 1'b0;
    void'($urandom(32'hf3ffba26));
    s = 9'($urandom) & 9'h183;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk) #1;
    chk({15'h0, low_rate_indicator}, 16'h1);
    wait_run();
    chk(16'(n < 2000), 16'h1);
    check_latched();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) s <= 9'($urandom);
      // Leave the control word dirty so each reset must restore it
      @(posedge clk) ctrl_wdata <= 16'h7fff & 16'($urandom);
      ctrl_wr <= 1'b1;
      @(posedge clk) ctrl_wr <= 1'b0;
      #1 chk(ctrl_rdata, ctrl_wdata);
      if (i[0]) begin
        @(posedge clk) ctrl_wdata <= 16'h8000 | 16'($urandom);
        ctrl_wr <= 1'b1;
        @(posedge clk) ctrl_wr <= 1'b0;
        #1 chk({14'h0, ctrl_rdata[15], low_rate_indicator}, 16'h3);
        wait_run();
        chk(16'(n), 16'(SOFT_CYC));
      end else begin
        // A pulse under 1 us is noise and must not disturb the latch
        @(posedge clk) {go, len} <= {1'b1, 10'd100};
        @(posedge clk) go <= 1'b0;
        repeat (140) @(posedge clk);
        #1 chk({15'h0, internal_reset}, 16'h0);
        @(posedge clk) {go, len} <= {1'b1, 10'd300};
        @(posedge clk) go <= 1'b0;
        repeat (260) @(posedge clk);
        #1 chk({15'h0, internal_reset}, 16'h1);
        wait_run();
      end
      check_latched();
    end
    end_sim();
  end
endmodule
`default_nettype wire
